//--- design/flash_seq_pkg.sv
`default_nettype none
package flash_seq_pkg;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned WORD_W = 14;
	localparam int unsigned ROW_LSB = 5;
	localparam int unsigned BLOCK_WORDS = 4;
	localparam logic [7:0] UNLOCK_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'haa;
	localparam logic [1:0] LAST_SLOT = 2'h3;
	localparam logic [13:0] ERASED_WORD = 14'h3fff;
	localparam int unsigned SETUP_CYCLES = 2;
	localparam int unsigned SKIP_CYCLES = 1;
	localparam int unsigned CLOCK_MHZ = 250;
	localparam int unsigned PROGRAM_TIME_US = 2000;
	localparam int unsigned PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
	localparam logic [1:0] PROT_NONE = 2'h3;
	localparam logic [1:0] PROT_LOW = 2'h2;
	localparam logic [1:0] PROT_HALF = 2'h1;
	localparam logic [12:0] PROT_LOW_TOP = 13'h00ff;
	localparam logic [12:0] PROT_HALF_TOP = 13'h07ff;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_SKIP,
		ST_BUSY,
		ST_DONE
	} seq_state_t;
endpackage : flash_seq_pkg
`default_nettype wire

//--- design/program_flash_self_erase_write.sv
// Function
// - an erase clears one whole 32-word row, nothing smaller
// - erase row comes from the upper 8 address bits; bits 4:0 ignored
// - erase starts only with program select, write enable and erase select set
// - write-start needs 55h then aah to the unlock port first
// - two setup cycles follow an erase start; those instructions are not run
// - erase halts the core about 2 ms while clocks keep running
// - execution resumes at the third instruction after the write-start
// - writes into a protected segment are refused
// - programming uses aligned four-word blocks, never across a boundary
// - four 14-bit holding buffers, picked by the low two address bits
// - low bits not 11 only load a buffer; start bit clears after 1 cycle
// - low bits 11 load last buffer, skip two cycles, halt 2 ms
// - after each long write all buffers become 3fff
// - write-start cannot be set unless write enable is already set
// - the unlock port has no storage; it only feeds the detector
`default_nettype none
module program_flash_self_erase_write #(
	parameter int unsigned PROGRAM_CYCLES = flash_seq_pkg::PROGRAM_CYCLES
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] flash_addr_low_in,
	input wire logic [4:0] flash_addr_high_in,
	input wire logic [7:0] flash_data_low_in,
	input wire logic [5:0] flash_data_high_in,
	input wire logic program_space_select_in,
	input wire logic write_enable_bit_in,
	input wire logic erase_select_in,
	input wire logic write_start_set_in,
	input wire logic unlock_write_in,
	input wire logic [7:0] unlock_data_in,
	input wire logic [1:0] write_protect_config_in,
	output logic write_start_out,
	output logic core_halt_signal_out,
	output logic core_skip_out,
	output logic write_refused_out,
	output logic array_erase_out,
	output logic array_program_out,
	output logic [12:0] array_addr_out,
	output logic [55:0] array_data_out
);
	typedef enum logic [1:0] {
		UL_IDLE,
		UL_GOT_FIRST,
		UL_ARMED
	} unlock_state_t;

	flash_seq_pkg::seq_state_t state_q, state_d;
	unlock_state_t unlock_q, unlock_d;
	logic [31:0] count_q, count_d;
	logic [13:0] buf_q [0:3];
	logic [12:0] addr_q;
	logic erase_q;
	logic start_q;
	logic halt_q;
	logic skip_q;
	logic refused_q;
	logic erase_pulse_q;
	logic prog_pulse_q;

	wire [12:0] full_addr = {flash_addr_high_in, flash_addr_low_in};
	wire [13:0] data_word = {flash_data_high_in, flash_data_low_in};
	wire [1:0] slot = flash_addr_low_in[1:0];
	wire idle = (state_q == flash_seq_pkg::ST_IDLE);
	wire allowed = write_enable_bit_in && program_space_select_in;
	wire armed = (unlock_q == UL_ARMED);
	wire start_ok = write_start_set_in && allowed && armed && idle;
	wire protected_addr = (write_protect_config_in == flash_seq_pkg::PROT_LOW
		&& full_addr <= flash_seq_pkg::PROT_LOW_TOP)
		|| (write_protect_config_in == flash_seq_pkg::PROT_HALF
		&& full_addr <= flash_seq_pkg::PROT_HALF_TOP)
		|| (write_protect_config_in == 2'h0);
	wire do_erase = start_ok && erase_select_in && !protected_addr;
	wire do_load = start_ok && !erase_select_in && !protected_addr;
	wire do_long = do_load && (slot == flash_seq_pkg::LAST_SLOT);
	wire refuse = start_ok && protected_addr;
	wire done = (state_q == flash_seq_pkg::ST_BUSY) && (count_q == 32'h0);
	wire finish = (state_q == flash_seq_pkg::ST_DONE);
	wire [12:0] erase_row = {full_addr[12:flash_seq_pkg::ROW_LSB], 5'h00};
	wire [12:0] block_base = {full_addr[12:2], 2'h0};

	// unlock detector: no stored value, only sequence state
	always_comb begin
		unlock_d = unlock_q;
		if (write_start_set_in) begin
			unlock_d = UL_IDLE;
		end else if (unlock_write_in) begin
			if (unlock_data_in == flash_seq_pkg::UNLOCK_FIRST) begin
				unlock_d = UL_GOT_FIRST;
			end else if (unlock_q == UL_GOT_FIRST
				&& unlock_data_in == flash_seq_pkg::UNLOCK_SECOND) begin
				unlock_d = UL_ARMED;
			end else begin
				unlock_d = UL_IDLE;
			end
		end
	end

	// sequencer: setup/skip cycles, then timed halt
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			flash_seq_pkg::ST_IDLE: begin
				if (do_erase) begin
					state_d = flash_seq_pkg::ST_SETUP;
					count_d = 32'(flash_seq_pkg::SETUP_CYCLES - 1);
				end else if (do_long) begin
					state_d = flash_seq_pkg::ST_SKIP;
					count_d = 32'(flash_seq_pkg::SKIP_CYCLES);
				end
			end
			flash_seq_pkg::ST_SETUP: begin
				if (count_q == 32'h0) begin
					state_d = flash_seq_pkg::ST_BUSY;
					count_d = 32'(PROGRAM_CYCLES - 1);
				end else begin
					count_d = count_q - 32'h1;
				end
			end
			flash_seq_pkg::ST_SKIP: begin
				if (count_q == 32'h0) begin
					state_d = flash_seq_pkg::ST_BUSY;
					count_d = 32'(PROGRAM_CYCLES - 1);
				end else begin
					count_d = count_q - 32'h1;
				end
			end
			flash_seq_pkg::ST_BUSY: begin
				if (count_q == 32'h0) begin
					state_d = flash_seq_pkg::ST_DONE;
				end else begin
					count_d = count_q - 32'h1;
				end
			end
			flash_seq_pkg::ST_DONE: begin
				state_d = flash_seq_pkg::ST_IDLE;
			end
			default: begin
				state_d = flash_seq_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= flash_seq_pkg::ST_IDLE;
			unlock_q <= UL_IDLE;
			count_q <= 32'h0;
		end else begin
			state_q <= state_d;
			unlock_q <= unlock_d;
			count_q <= count_d;
		end
	end

	// four holding buffers
	genvar i;
	generate
		for (i = 0; i < flash_seq_pkg::BLOCK_WORDS; i++) begin : g_buf
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in) begin
					buf_q[i] <= flash_seq_pkg::ERASED_WORD;
				end else if (finish && !erase_q) begin
					buf_q[i] <= flash_seq_pkg::ERASED_WORD;
				end else if (do_load && slot == 2'(i)) begin
					buf_q[i] <= data_word;
				end
			end
		end
	endgenerate

	// operation address and kind, captured when an erase or long write starts
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			addr_q <= 13'h0;
			erase_q <= 1'b0;
		end else if (do_erase) begin
			addr_q <= erase_row;
			erase_q <= 1'b1;
		end else if (do_long) begin
			addr_q <= block_base;
			erase_q <= 1'b0;
		end
	end

	// write-start bit
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			start_q <= 1'b0;
		end else if (do_erase || do_long) begin
			start_q <= 1'b1;
		end else if (do_load) begin
			start_q <= 1'b1;
		end else if (done || idle) begin
			start_q <= 1'b0;
		end
	end

	// core stall and skip indications
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			halt_q <= 1'b0;
			skip_q <= 1'b0;
		end else begin
			halt_q <= (state_d == flash_seq_pkg::ST_SETUP)
				|| (state_d == flash_seq_pkg::ST_BUSY);
			skip_q <= (state_d == flash_seq_pkg::ST_SKIP);
		end
	end

	// refusal pulse
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			refused_q <= 1'b0;
		end else begin
			refused_q <= refuse;
		end
	end

	// array strobes; buffers still hold the block while the program strobe stands
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			erase_pulse_q <= 1'b0;
			prog_pulse_q <= 1'b0;
		end else begin
			erase_pulse_q <= done && erase_q;
			prog_pulse_q <= done && !erase_q;
		end
	end

	assign write_start_out = start_q;
	assign core_halt_signal_out = halt_q;
	assign core_skip_out = skip_q;
	assign write_refused_out = refused_q;
	assign array_erase_out = erase_pulse_q;
	assign array_program_out = prog_pulse_q;
	assign array_addr_out = addr_q;
	assign array_data_out = {buf_q[3], buf_q[2], buf_q[1], buf_q[0]};
endmodule : program_flash_self_erase_write
`default_nettype wire

//--- testbench/core_model.sv
`default_nettype none
module core_model (
	input wire logic clock_in,
	input wire logic halt_in,
	input wire logic skip_in,
	output logic [12:0] addr_out,
	output logic [13:0] data_out,
	output logic [2:0] ctl_out,
	output logic start_out,
	output logic unlock_out,
	output logic [7:0] key_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {addr_out, data_out, ctl_out, start_out, unlock_out, key_out} = '0;
	task automatic run(input logic [12:0] a, input logic [13:0] d, input logic [2:0] c,
		input logic [7:0] k);
		@(negedge clock_in);
		{addr_out, data_out, ctl_out, unlock_out, key_out} = {a, d, c, 1'b1, 8'h55};
		@(negedge clock_in);
		key_out = k;
		@(negedge clock_in);
		{unlock_out, key_out, start_out} = {1'b0, ~k, 1'b1};
		@(negedge clock_in);
		start_out = 1'b0;
		repeat (2) @(negedge clock_in);
		for (int i = 0; i < 99 && (halt_in || skip_in); i++) @(negedge clock_in);
	endtask : run
endmodule : core_model
`default_nettype wire

//--- testbench/flash_seq_asserts.sv
`default_nettype none
module flash_seq_asserts #(parameter int unsigned PROGRAM_CYCLES = 20) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic write_start_set_in,
	input wire logic write_enable_bit_in,
	input wire logic [1:0] write_protect_config_in,
	input wire logic write_start_out,
	input wire logic core_halt_signal_out,
	input wire logic core_skip_out,
	input wire logic array_erase_out,
	input wire logic array_program_out,
	input wire logic [12:0] array_addr_out,
	input wire logic [55:0] array_data_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	logic [31:0] halt_n_q;
	always_ff @(posedge clock_in or posedge rst_in)
		if (rst_in) halt_n_q <= '0;
		else halt_n_q <= core_halt_signal_out ? halt_n_q + 32'h1 : '0;
	sequence s_skip_halt; core_skip_out ##[1:3] core_halt_signal_out; endsequence
	sequence s_short_done; !write_start_out && !core_halt_signal_out; endsequence
	chk_skip_then_halt: assert property ($rose(core_skip_out) |-> s_skip_halt)
		else $error("skip without halt");
	chk_short_write: assert property ($rose(write_start_out)
		&& !core_halt_signal_out && !core_skip_out |=> s_short_done)
		else $error("short write stalled");
	chk_halt_length: assert property ($fell(core_halt_signal_out)
		|-> halt_n_q >= PROGRAM_CYCLES && halt_n_q <= PROGRAM_CYCLES + 4)
		else $error("halt length");
	chk_halt_release: assert property ($fell(core_halt_signal_out) |-> !write_start_out)
		else $error("start bit left set");
	chk_erase_row: assert property (array_erase_out |-> array_addr_out[4:0] == 5'h0)
		else $error("erase row misaligned");
	chk_block_align: assert property (array_program_out |-> array_addr_out[1:0] == 2'h0)
		else $error("block misaligned");
	chk_buffer_reset: assert property (array_program_out |=> array_data_out == {4{14'h3fff}})
		else $error("buffers not reset");
	chk_enable_needed: assert property (write_start_set_in && !write_enable_bit_in |=> !write_start_out)
		else $error("start without enable");
	chk_protect_all: assert property (write_start_set_in
		&& write_protect_config_in == 2'h0 && !write_start_out
		|=> !$rose(core_halt_signal_out))
		else $error("protected start ran");
endmodule : flash_seq_asserts
bind program_flash_self_erase_write flash_seq_asserts #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) chk (
	.clock_in, .rst_in, .write_start_set_in, .write_enable_bit_in, .write_protect_config_in,
	.write_start_out, .core_halt_signal_out, .core_skip_out, .array_erase_out,
	.array_program_out, .array_addr_out, .array_data_out);
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [12:0] a, aa;
	logic [13:0] d;
	logic [2:0] c;
	logic st, uw, ws, halt, skip, refused, erp, pgp;
	logic [7:0] key;
	logic [1:0] prot = 2'h3;
	logic [55:0] ad;
	int n_fail = 0;
	int checks = 0;
	int seed = 32'h6b3e29d4;
	logic [13:0] hold_q [4];
	logic [70:0] exp_q [$];
	always #2 clock_in = ~clock_in;
	core_model core (.clock_in, .halt_in(halt), .skip_in(skip), .addr_out(a), .data_out(d),
		.ctl_out(c), .start_out(st), .unlock_out(uw), .key_out(key));
	program_flash_self_erase_write #(.PROGRAM_CYCLES(20)) DUT (.clock_in, .rst_in,
		.flash_addr_low_in(a[7:0]), .flash_addr_high_in(a[12:8]), .flash_data_low_in(d[7:0]),
		.flash_data_high_in(d[13:8]), .program_space_select_in(c[2]),
		.write_enable_bit_in(c[1]), .erase_select_in(c[0]), .write_start_set_in(st),
		.unlock_write_in(uw), .unlock_data_in(key), .write_protect_config_in(prot),
		.write_start_out(ws), .core_halt_signal_out(halt), .core_skip_out(skip),
		.write_refused_out(refused), .array_erase_out(erp), .array_program_out(pgp),
		.array_addr_out(aa), .array_data_out(ad));
	task automatic cmp(input logic [70:0] got, input logic [70:0] want);
		checks++;
		if (got !== want) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h want=%h", $time, got, want);
		end
	endtask : cmp
	task automatic conclude;
		if (n_fail == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	always @(negedge clock_in) if (!rst_in && (erp || pgp || refused))
		cmp(refused ? {2'h2, 69'h0} : {erp ? 2'h0 : 2'h1, aa, ad},
			exp_q.size() ? exp_q.pop_front() : '1);
	initial begin
		logic [31:0] r, q;
		logic ok, prt;
		repeat (5) @(negedge clock_in);
		rst_in = 1'b0;
		cmp({15'h0, ad}, {15'h0, {4{flash_seq_pkg::ERASED_WORD}}});
		hold_q = '{default: flash_seq_pkg::ERASED_WORD};
		for (int i = 0; i < 80; i++) begin
			r = $random(seed);
			q = $random(seed);
			prot = (r[8] & r[9]) || q[1:0] == 2'h3 ? r[7:6] : 2'h3;
			ok = (r[4] | r[5]) && (r[0] | r[1]) && (r[2] | r[3]);
			prt = prot == 2'h0 || (prot == 2'h1 && q[12:0] <= 13'h07ff)
				|| (prot == 2'h2 && q[12:0] <= 13'h00ff);
			if (ok && prt) begin
				exp_q.push_back({2'h2, 69'h0});
			end else if (ok && r[8] && r[9]) begin
				exp_q.push_back({2'h0, q[12:5], 5'h0,
					hold_q[3], hold_q[2], hold_q[1], hold_q[0]});
			end else if (ok) begin
				hold_q[q[1:0]] = q[29:16];
				if (q[1:0] == 2'h3) begin
					exp_q.push_back({2'h1, q[12:2], 2'h0,
						hold_q[3], hold_q[2], hold_q[1], hold_q[0]});
					hold_q = '{default: flash_seq_pkg::ERASED_WORD};
				end
			end
			core.run(q[12:0], q[29:16], {r[4] | r[5], r[0] | r[1], r[8] & r[9]},
				(r[2] | r[3]) ? 8'haa : 8'h54);
		end
		repeat (2) @(negedge clock_in);
		cmp(71'(exp_q.size()), 71'h0);
		conclude();
	end
	initial begin
		#200000;
		n_fail++;
		conclude();
	end
endmodule : tb
`default_nettype wire
